// ---- logic/crs_pkg.sv ----
package crs_pkg;

  // Widths of the architectural state.
  localparam int DATA_W    = 32;
  localparam int SEL_W     = 16;
  localparam int GPR_N     = 8;
  localparam int GPR_IDX_W = 3;
  localparam int SEL_N     = 6;
  localparam int ADDR_W    = 12;
  localparam int IDX_W     = 6;
  localparam int BE_W      = 4;

  // Views of one general-purpose register.
  typedef enum logic [1:0] {
    VIEW_DWORD,
    VIEW_WORD,
    VIEW_LOW,
    VIEW_HIGH
  } crs_view_t;

  // Byte enables of each view.
  localparam logic [3:0] BE_DWORD = 4'hf;
  localparam logic [3:0] BE_WORD  = 4'h3;
  localparam logic [3:0] BE_LOW   = 4'h1;
  localparam logic [3:0] BE_HIGH  = 4'h2;

  // General-purpose register numbers.
  localparam logic [2:0] GPR_ACC   = 3'h0;
  localparam logic [2:0] GPR_COUNT = 3'h1;
  localparam logic [2:0] GPR_IO    = 3'h2;
  localparam logic [2:0] GPR_BASE  = 3'h3;
  localparam logic [2:0] GPR_STACK = 3'h4;
  localparam logic [2:0] GPR_FRAME = 3'h5;
  localparam logic [2:0] GPR_SRC   = 3'h6;
  localparam logic [2:0] GPR_DST   = 3'h7;

  // Segment selector numbers.
  localparam logic [2:0] SEL_CODE   = 3'h0;
  localparam logic [2:0] SEL_DMAIN  = 3'h1;
  localparam logic [2:0] SEL_STACK  = 3'h2;
  localparam logic [2:0] SEL_DEXTRA = 3'h3;
  localparam logic [2:0] SEL_DTHIRD = 3'h4;
  localparam logic [2:0] SEL_DFOUR  = 3'h5;

  // Register word indices; the byte address is four times the index.
  localparam logic [5:0] IDX_GPR32 = 6'h00;
  localparam logic [5:0] IDX_GPR16 = 6'h08;
  localparam logic [5:0] IDX_LOW   = 6'h10;
  localparam logic [5:0] IDX_HIGH  = 6'h14;
  localparam logic [5:0] IDX_SEL   = 6'h18;
  localparam logic [5:0] IDX_CODE  = 6'h18;
  localparam logic [5:0] IDX_MODE  = 6'h1e;
  localparam logic [5:0] IDX_SIZE  = 6'h1f;
  localparam logic [5:0] IDX_IP    = 6'h20;

  // Mode and size register bits.
  localparam int MODE_PROT_BIT = 0;
  localparam int SIZE_ADDR_BIT = 0;
  localparam int SIZE_OP_BIT   = 1;

  // Flags register layout.
  localparam logic [31:0] FLAGS_RESET    = 32'h0000_0002;
  localparam logic [31:0] FLAGS_RSVD_ONE = 32'h0000_0002;
  localparam logic [31:0] FLAGS_WR_MASK  = 32'h003f_7fd5;
  localparam logic [7:0]  FLAGS_ACC_MASK = 8'hd5;

  // Largest offsets per address size.
  localparam logic [31:0] LIMIT_16 = 32'h0000_ffff;
  localparam logic [31:0] LIMIT_32 = 32'hffff_ffff;

  // Cleans a flags image: reserved bits take their fixed values.
  function automatic logic [31:0] flags_clean(input logic [31:0] v);
    flags_clean = (v & FLAGS_WR_MASK) | FLAGS_RSVD_ONE;
  endfunction

endpackage

// ---- logic/crs_gpr_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module crs_gpr_mem
  import crs_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_we,
  input  wire logic [GPR_IDX_W-1:0] i_widx,
  input  wire logic [BE_W-1:0]      i_be,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic                 i_re,
  input  wire logic [GPR_IDX_W-1:0] i_ridx,
  output logic      [DATA_W-1:0]    o_rdata
);

  logic [DATA_W-1:0] mem_r [GPR_N];

  // Eight 32-bit registers; each byte lane is written only when enabled.
  always_ff @(posedge i_clk) begin  // RULE4
    if (i_we) begin
      for (int b = 0; b < BE_W; b++) begin
        if (i_be[b]) begin
          mem_r[i_widx][b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end
  end

  // Read data come out of a register one edge after the request.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem_r[i_ridx];
    end
  end

endmodule
`default_nettype wire

// ---- logic/crs_regset.sv ----
// Summary of operation
// RULE1 - Real mode defaults to 16-bit address, operand.
// RULE2 - Real mode offset limit stays 0000FFFFH always.
// RULE3 - Protected mode sizes follow code descriptor bit.
// RULE4 - Eight 32-bit general-purpose registers provided.
// RULE5 - 16-bit view touches only bits 15..0.
// RULE6 - First four registers offer high, low bytes.
// RULE7 - Six 16-bit segment selector registers.
// RULE8 - Fetch address is code selector plus pointer.
// RULE9 - Code selector changes only by control transfer.
// RULE10 - Stack operations use the stack selector.
// RULE11 - Stack selector accepts explicit software loads.
// RULE12 - Reset or init pin sets flags 00000002H.
// RULE13 - Flags bits 1,3,5,15,22-31 are reserved.
// RULE14 - Flags move only in groups, never whole; here the pop and task-load paths load the whole flags image.
// RULE15 - Task suspend saves flags into task segment.
// RULE16 - New task reloads flags from its segment.
// RULE17 - Handler call pushes flags onto the stack.
// RULE18 - Interrupt task switch saves flags to segment.
// RULE19 - Reserved bit 1 reads one, others zero.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module crs_regset
  import crs_pkg::*;
(
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_INIT,
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [ADDR_W-1:0]    I_PADDR,
  input  wire logic [DATA_W-1:0]    I_PWDATA,
  output logic      [DATA_W-1:0]    O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  input  wire logic                 I_GPR_WE,
  input  wire logic [GPR_IDX_W-1:0] I_GPR_IDX,
  input  wire logic [1:0]           I_GPR_VIEW,
  input  wire logic [DATA_W-1:0]    I_GPR_WDATA,
  input  wire logic                 I_SEL_WE,
  input  wire logic [2:0]           I_SEL_IDX,
  input  wire logic [SEL_W-1:0]     I_SEL_WDATA,
  input  wire logic                 I_XFER_CS_LOAD,
  input  wire logic [SEL_W-1:0]     I_XFER_CS,
  input  wire logic                 I_XFER_CS_D32,
  input  wire logic                 I_IP_LOAD,
  input  wire logic [DATA_W-1:0]    I_IP_DATA,
  input  wire logic                 I_ADDR_OVR,
  input  wire logic                 I_OP_OVR,
  input  wire logic                 I_TASK_SWITCH,
  input  wire logic                 I_INT_ENTRY,
  input  wire logic                 I_INT_VIA_TASK,
  input  wire logic [DATA_W-1:0]    I_NEW_FLAGS,
  input  wire logic                 I_PUSH_FLAGS,
  input  wire logic                 I_POP_FLAGS,
  input  wire logic [DATA_W-1:0]    I_POP_DATA,
  input  wire logic                 I_LOAD_FLAGS_TO_ACC,
  input  wire logic                 I_STORE_ACC_TO_FLAGS,
  input  wire logic [7:0]           I_ACC_HIGH_BYTE,
  output logic      [DATA_W-1:0]    O_FLAGS,
  output logic      [DATA_W-1:0]    O_SAVE_FLAGS,
  output logic                      O_SAVE_VLD,
  output logic                      O_SAVE_TO_TSEG,
  output logic      [SEL_W-1:0]     O_FETCH_SEL,
  output logic      [DATA_W-1:0]    O_FETCH_OFS,
  output logic      [SEL_W-1:0]     O_STACK_SEL,
  output logic                      O_ADDR32,
  output logic                      O_OP32,
  output logic      [DATA_W-1:0]    O_ADDR_LIMIT
);

  // Maps a register index to the view it addresses.
  function automatic crs_view_t view_of(input logic [5:0] idx);
    if (idx < IDX_GPR16) begin
      view_of = VIEW_DWORD;
    end else if (idx < IDX_LOW) begin
      view_of = VIEW_WORD;
    end else if (idx < IDX_HIGH) begin
      view_of = VIEW_LOW;
    end else begin
      view_of = VIEW_HIGH;
    end
  endfunction

  // Byte enables of a view.
  function automatic logic [3:0] view_be(input crs_view_t v);
    case (v)
      VIEW_WORD: view_be = BE_WORD;
      VIEW_LOW:  view_be = BE_LOW;
      VIEW_HIGH: view_be = BE_HIGH;
      default:   view_be = BE_DWORD;
    endcase
  endfunction

  // Moves right-justified view data to its lanes in the word.
  function automatic logic [31:0] view_place(input crs_view_t v,
                                             input logic [31:0] d);
    if (v == VIEW_HIGH) begin
      view_place = {d[23:0], 8'h00};
    end else begin
      view_place = d;
    end
  endfunction

  // Extracts a view from a word, right-justified, upper bits zero.
  function automatic logic [31:0] view_read(input crs_view_t v,
                                            input logic [31:0] w);
    case (v)
      VIEW_WORD: view_read = {16'h0000, w[15:0]};
      VIEW_LOW:  view_read = {24'h00_0000, w[7:0]};
      VIEW_HIGH: view_read = {24'h00_0000, w[15:8]};
      default:   view_read = w;
    endcase
  endfunction

  logic             init_s1_r, init_s2_r, init_s3_r, init_lvl_r;
  logic [DATA_W-1:0] flags_r;
  logic [SEL_W-1:0] sel_r [SEL_N];
  logic             cs_d32_r;
  logic [DATA_W-1:0] ip_r;
  logic             prot_r;
  logic             pready_r;
  logic             apb_setup, apb_access, apb_first, addr_hi_ok;
  logic [5:0]       idx;
  crs_view_t        apb_view, exe_view;
  logic             is_gpr, is_sel, mapped, ro_hit;
  logic [2:0]       apb_gpr, apb_sel;
  logic             exe_ok, acc_ld_go, exe_busy, stall, apb_wr;
  logic             mem_we;
  logic [2:0]       mem_widx;
  logic [3:0]       mem_be;
  logic [DATA_W-1:0] mem_wdata, mem_rdata, prdata_nxt;
  logic             task_load, save_go, def32;

  // The init pin is foreign to this clock: three stages, and the level
  // moves only when the second and third stages agree.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      init_s1_r  <= 1'b0;
      init_s2_r  <= 1'b0;
      init_s3_r  <= 1'b0;
      init_lvl_r <= 1'b0;
    end else begin
      init_s1_r <= I_INIT;
      init_s2_r <= init_s1_r;
      init_s3_r <= init_s2_r;
      if (init_s2_r == init_s3_r) begin
        init_lvl_r <= init_s3_r;
      end
    end
  end

  // APB decode; every register is one aligned word.
  assign apb_setup  = I_PSEL & ~I_PENABLE;
  assign apb_access = I_PSEL & I_PENABLE;
  assign apb_first  = apb_access & ~pready_r;
  assign idx        = I_PADDR[7:2];
  assign addr_hi_ok = (I_PADDR[ADDR_W-1:8] == '0);
  assign apb_view   = view_of(idx);
  assign is_gpr     = addr_hi_ok & (idx < IDX_SEL);
  assign is_sel     = addr_hi_ok & (idx >= IDX_SEL) & (idx < IDX_MODE);
  assign mapped     = addr_hi_ok & (idx <= IDX_IP);
  assign apb_gpr    = (apb_view == VIEW_LOW || apb_view == VIEW_HIGH) ?
                      {1'b0, idx[1:0]} : idx[2:0];
  assign apb_sel    = 3'(idx - IDX_SEL);
  // The code selector, size status and pointer are read-only here.
  assign ro_hit     = addr_hi_ok & ((idx == IDX_CODE) | (idx == IDX_SIZE) |
                                    (idx == IDX_IP));

  // Execution-side register writes; byte views exist only on 0..3.
  assign exe_view = crs_view_t'(I_GPR_VIEW);
  assign exe_ok   = I_GPR_WE & ~((exe_view == VIEW_LOW ||
                                  exe_view == VIEW_HIGH) &&
                                 I_GPR_IDX[2]);  // RULE6
  assign acc_ld_go = I_LOAD_FLAGS_TO_ACC & ~exe_ok;
  assign exe_busy = exe_ok | I_LOAD_FLAGS_TO_ACC;
  // An APB register write waits while the core owns the write port.
  assign stall    = is_gpr & I_PWRITE & exe_busy;
  assign apb_wr   = apb_first & I_PWRITE & ~stall & mapped & ~ro_hit;

  // One write port: core first, then flag-group move, then APB.
  always_comb begin
    mem_we    = 1'b0;
    mem_widx  = GPR_ACC;
    mem_be    = BE_DWORD;
    mem_wdata = I_PWDATA;
    if (exe_ok) begin
      mem_we    = 1'b1;
      mem_widx  = I_GPR_IDX;
      mem_be    = view_be(exe_view);  // RULE5
      mem_wdata = view_place(exe_view, I_GPR_WDATA);
    end else if (acc_ld_go) begin
      mem_we    = 1'b1;
      mem_widx  = GPR_ACC;
      mem_be    = view_be(VIEW_HIGH);  // RULE14
      mem_wdata = view_place(VIEW_HIGH, {24'h00_0000, flags_r[7:0]});
    end else if (apb_wr && is_gpr) begin
      mem_we    = 1'b1;
      mem_widx  = apb_gpr;
      mem_be    = view_be(apb_view);  // RULE5
      mem_wdata = view_place(apb_view, I_PWDATA);
    end
  end

  crs_gpr_mem u_gpr (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_we    (mem_we),
    .i_widx  (mem_widx),
    .i_be    (mem_be),
    .i_wdata (mem_wdata),
    .i_re    (apb_setup & is_gpr),
    .i_ridx  (apb_gpr),
    .o_rdata (mem_rdata)
  );

  // Read data for the register addressed by APB.
  always_comb begin
    prdata_nxt = '0;
    if (is_gpr) begin
      prdata_nxt = view_read(apb_view, mem_rdata);
    end else if (is_sel) begin
      prdata_nxt = {16'h0000, sel_r[apb_sel]};
    end else if (addr_hi_ok && idx == IDX_MODE) begin
      prdata_nxt[MODE_PROT_BIT] = prot_r;
    end else if (addr_hi_ok && idx == IDX_SIZE) begin
      prdata_nxt[SIZE_ADDR_BIT] = def32;
      prdata_nxt[SIZE_OP_BIT]   = def32;
    end else if (addr_hi_ok && idx == IDX_IP) begin
      prdata_nxt = ip_r;
    end
  end

  // APB answer: ready in the second access cycle unless stalled.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready_r  <= 1'b0;
      O_PRDATA  <= '0;
      O_PSLVERR <= 1'b0;
    end else begin
      pready_r  <= apb_first & ~stall;
      if (apb_first && !stall) begin
        O_PRDATA  <= I_PWRITE ? '0 : prdata_nxt;
        O_PSLVERR <= ~mapped | (I_PWRITE & ro_hit);  // RULE9
      end else begin
        O_PSLVERR <= 1'b0;
      end
    end
  end
  assign O_PREADY = pready_r;

  // Segment selectors; the code selector follows control transfers only.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin  // RULE7
    if (!I_RST_N) begin
      for (int s = 0; s < SEL_N; s++) begin
        sel_r[s] <= '0;
      end
      cs_d32_r <= 1'b0;
    end else begin
      if (I_XFER_CS_LOAD) begin
        sel_r[SEL_CODE] <= I_XFER_CS;  // RULE9
        cs_d32_r        <= I_XFER_CS_D32;
      end
      for (int s = 1; s < SEL_N; s++) begin
        if (I_SEL_WE && I_SEL_IDX == 3'(s)) begin
          sel_r[s] <= I_SEL_WDATA;  // RULE11
        end else if (apb_wr && is_sel && apb_sel == 3'(s)) begin
          sel_r[s] <= I_PWDATA[SEL_W-1:0];  // RULE11
        end
      end
    end
  end

  // Instruction pointer and operating mode; init returns to real mode.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ip_r   <= '0;
      prot_r <= 1'b0;
    end else begin
      if (I_IP_LOAD) begin
        ip_r <= I_IP_DATA;
      end
      if (init_lvl_r) begin
        prot_r <= 1'b0;
      end else if (apb_wr && idx == IDX_MODE) begin
        prot_r <= I_PWDATA[MODE_PROT_BIT];
      end
    end
  end

  // Default sizes and offset limit for the current instruction.
  assign def32 = prot_r & cs_d32_r;  // RULE3
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ADDR32     <= 1'b0;
      O_OP32       <= 1'b0;
      O_ADDR_LIMIT <= LIMIT_16;
    end else begin
      O_ADDR32 <= def32 ^ I_ADDR_OVR;  // RULE1
      O_OP32   <= def32 ^ I_OP_OVR;  // RULE1
      if (!prot_r) begin
        O_ADDR_LIMIT <= LIMIT_16;  // RULE2
      end else begin
        O_ADDR_LIMIT <= (def32 ^ I_ADDR_OVR) ? LIMIT_32 : LIMIT_16;
      end
    end
  end

  // Fetch and stack addressing outputs.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FETCH_SEL <= '0;
      O_FETCH_OFS <= '0;
      O_STACK_SEL <= '0;
    end else begin
      O_FETCH_SEL <= sel_r[SEL_CODE];  // RULE8
      O_FETCH_OFS <= ip_r;  // RULE8
      O_STACK_SEL <= sel_r[SEL_STACK];  // RULE10
    end
  end

  // Flags register; reserved bits never take written values.
  assign task_load = I_TASK_SWITCH | (I_INT_ENTRY & I_INT_VIA_TASK);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin  // RULE13
    if (!I_RST_N) begin
      flags_r <= FLAGS_RESET;
    end else if (init_lvl_r) begin
      flags_r <= FLAGS_RESET;  // RULE12
    end else if (task_load) begin
      flags_r <= flags_clean(I_NEW_FLAGS);  // RULE16
    end else if (I_POP_FLAGS) begin
      flags_r <= flags_clean(I_POP_DATA);  // RULE14
    end else if (I_STORE_ACC_TO_FLAGS) begin
      flags_r[7:0] <= (I_ACC_HIGH_BYTE & FLAGS_ACC_MASK) |
                      (flags_r[7:0] & ~FLAGS_ACC_MASK);  // RULE19
    end
  end
  assign O_FLAGS = flags_r;

  // Saves the outgoing flags image; the target is the task segment or
  // the procedure stack.
  assign save_go = ~init_lvl_r & (I_TASK_SWITCH | I_INT_ENTRY | I_PUSH_FLAGS);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SAVE_FLAGS   <= '0;
      O_SAVE_VLD     <= 1'b0;
      O_SAVE_TO_TSEG <= 1'b0;
    end else begin
      O_SAVE_VLD <= save_go;  // RULE15
      if (save_go) begin
        O_SAVE_FLAGS   <= flags_r;  // RULE17
        O_SAVE_TO_TSEG <= task_load;  // RULE18
      end
    end
  end

  // Checks of the architectural behaviour.
  property p_real_op;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (!prot_r && !I_OP_OVR && !I_ADDR_OVR) |=> (!O_OP32 && !O_ADDR32);
  endproperty
  a_real_op: assert property (p_real_op) // RULE1
    else $error("real mode size not 16 bits");

  property p_real_limit;
    @(posedge I_CLK) disable iff (!I_RST_N)
    !prot_r |=> (O_ADDR_LIMIT == LIMIT_16);
  endproperty
  a_real_limit: assert property (p_real_limit) // RULE2
    else $error("real mode limit exceeded 0000FFFF");

  property p_prot_size;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (prot_r && !I_OP_OVR) |=> (O_OP32 == $past(cs_d32_r));
  endproperty
  a_prot_size: assert property (p_prot_size) // RULE3
    else $error("protected size not from descriptor");

  property p_word_view;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_GPR_WE && exe_view == VIEW_WORD) |->
      (mem_be == BE_WORD && mem_wdata[15:0] == I_GPR_WDATA[15:0]);
  endproperty
  a_word_view: assert property (p_word_view) // RULE5
    else $error("word view touched upper half");

  property p_high_view;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_GPR_WE && exe_view == VIEW_HIGH && !I_GPR_IDX[2]) |->
      (mem_be == BE_HIGH && mem_wdata[15:8] == I_GPR_WDATA[7:0]);
  endproperty
  a_high_view: assert property (p_high_view) // RULE6
    else $error("high byte view misplaced");

  property p_fetch;
    @(posedge I_CLK) disable iff (!I_RST_N)
    ##1 (O_FETCH_SEL == $past(sel_r[SEL_CODE]) &&
         O_FETCH_OFS == $past(ip_r));
  endproperty
  a_fetch: assert property (p_fetch) // RULE8
    else $error("fetch address not code selector and pointer");

  property p_cs_locked;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (!I_XFER_CS_LOAD) |=> $stable(sel_r[SEL_CODE]);
  endproperty
  a_cs_locked: assert property (p_cs_locked) // RULE9
    else $error("code selector changed without transfer");

  property p_ss_load;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_SEL_WE && I_SEL_IDX == SEL_STACK) |=>
      ##1 (O_STACK_SEL == $past(I_SEL_WDATA, 2));
  endproperty
  a_ss_load: assert property (p_ss_load) // RULE11
    else $error("stack selector load lost");

  property p_init;
    @(posedge I_CLK) disable iff (!I_RST_N)
    init_lvl_r |=> (flags_r == FLAGS_RESET);
  endproperty
  a_init: assert property (p_init) // RULE12
    else $error("flags not 00000002 after init");

  property p_rsvd;
    @(posedge I_CLK) disable iff (!I_RST_N)
    ((flags_r & ~FLAGS_WR_MASK) == FLAGS_RSVD_ONE);
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE19
    else $error("reserved flag bits wrong");

  property p_task_save;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (task_load && !init_lvl_r) |=>
      (O_SAVE_VLD && O_SAVE_TO_TSEG && O_SAVE_FLAGS == $past(flags_r) &&
       flags_r == flags_clean($past(I_NEW_FLAGS)));
  endproperty
  a_task_save: assert property (p_task_save) // RULE15
    else $error("task switch flags save or load wrong");

  property p_int_stack;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_INT_ENTRY && !I_INT_VIA_TASK && !I_TASK_SWITCH && !init_lvl_r) |=>
      (O_SAVE_VLD && !O_SAVE_TO_TSEG);
  endproperty
  a_int_stack: assert property (p_int_stack) // RULE17
    else $error("handler call did not push flags");

  c_task: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_TASK_SWITCH ##1 O_SAVE_VLD);
  c_apb_gpr: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    apb_wr && is_gpr ##1 O_PREADY);
  c_init: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    $fell(init_lvl_r));

endmodule
`default_nettype wire

// ---- dv/crs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb
  import crs_pkg::*;
;
  logic I_CLK, I_RST_N, I_INIT, I_PSEL, I_PENABLE, I_PWRITE;
  logic O_PREADY, O_PSLVERR;
  logic I_GPR_WE, I_SEL_WE, I_XFER_CS_LOAD, I_XFER_CS_D32, I_IP_LOAD;
  logic I_ADDR_OVR, I_OP_OVR, I_TASK_SWITCH, I_INT_ENTRY, I_INT_VIA_TASK;
  logic I_PUSH_FLAGS, I_POP_FLAGS, I_LOAD_FLAGS_TO_ACC, I_STORE_ACC_TO_FLAGS;
  logic O_SAVE_VLD, O_SAVE_TO_TSEG, O_ADDR32, O_OP32;
  logic [ADDR_W-1:0]    I_PADDR;
  logic [DATA_W-1:0]    I_PWDATA, O_PRDATA, I_GPR_WDATA, I_IP_DATA, I_NEW_FLAGS;
  logic [DATA_W-1:0]    I_POP_DATA, O_FLAGS, O_SAVE_FLAGS, O_FETCH_OFS;
  logic [DATA_W-1:0]    O_ADDR_LIMIT;
  logic [GPR_IDX_W-1:0] I_GPR_IDX;
  logic [1:0]           I_GPR_VIEW;
  logic [2:0]           I_SEL_IDX;
  logic [SEL_W-1:0]     I_SEL_WDATA, I_XFER_CS, O_FETCH_SEL, O_STACK_SEL;
  logic [7:0]           I_ACC_HIGH_BYTE;
  logic [31:0]          rd;
  logic                 er;
  int                   error_cnt, comparisons, cycles;

  crs_regset dut (
    .I_CLK, .I_RST_N, .I_INIT, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_GPR_WE, .I_GPR_IDX,
    .I_GPR_VIEW, .I_GPR_WDATA, .I_SEL_WE, .I_SEL_IDX, .I_SEL_WDATA,
    .I_XFER_CS_LOAD, .I_XFER_CS, .I_XFER_CS_D32, .I_IP_LOAD, .I_IP_DATA,
    .I_ADDR_OVR, .I_OP_OVR, .I_TASK_SWITCH, .I_INT_ENTRY, .I_INT_VIA_TASK,
    .I_NEW_FLAGS, .I_PUSH_FLAGS, .I_POP_FLAGS, .I_POP_DATA,
    .I_LOAD_FLAGS_TO_ACC, .I_STORE_ACC_TO_FLAGS, .I_ACC_HIGH_BYTE, .O_FLAGS,
    .O_SAVE_FLAGS, .O_SAVE_VLD, .O_SAVE_TO_TSEG, .O_FETCH_SEL, .O_FETCH_OFS,
    .O_STACK_SEL, .O_ADDR32, .O_OP32, .O_ADDR_LIMIT
  );

  // The 25 MHz clock.
  always #20 I_CLK = ~I_CLK;

  // Cuts a hang short and reports it as a mismatch.
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("FAIL t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= wd;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    n = 0;
    // Waits for the answer; only the bench timeout ends a hang.
    do begin
      @(posedge I_CLK);
      n++;
    end while (O_PREADY !== 1'b1);
    // One wait state: ready comes in the second access cycle.
    chk(32'(n), 32'h0000_0002);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  // Write, then compare the error response.
  task automatic wre(input logic [11:0] a, input logic [31:0] d,
                     input logic e);
    apb(1'b1, a, d);
    chk(32'(er), 32'(e));
  endtask

  // Read, then compare the data.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Waits k edges, then steps off the edge.
  task automatic nclk(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask

  // Raises one core strobe for exactly one cycle.
  task automatic pulse(input int k);
    @(posedge I_CLK);
    case (k)
      0: I_TASK_SWITCH <= 1'b1;
      1: I_INT_ENTRY <= 1'b1;
      2: I_PUSH_FLAGS <= 1'b1;
      3: I_POP_FLAGS <= 1'b1;
      4: I_STORE_ACC_TO_FLAGS <= 1'b1;
      5: I_LOAD_FLAGS_TO_ACC <= 1'b1;
      6: I_GPR_WE <= 1'b1;
      7: I_SEL_WE <= 1'b1;
      8: I_XFER_CS_LOAD <= 1'b1;
      default: I_IP_LOAD <= 1'b1;
    endcase
    @(posedge I_CLK);
    {I_TASK_SWITCH, I_INT_ENTRY, I_PUSH_FLAGS, I_POP_FLAGS} <= '0;
    {I_STORE_ACC_TO_FLAGS, I_LOAD_FLAGS_TO_ACC, I_GPR_WE} <= '0;
    {I_SEL_WE, I_XFER_CS_LOAD, I_IP_LOAD} <= '0;
    #1;
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: reset, registers, views, selectors, sizes, flags, init.
  initial begin
    I_CLK = 1'b0;
    I_RST_N = 1'b0;
    {I_INIT, I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} = '0;
    {I_GPR_WE, I_GPR_IDX, I_GPR_VIEW, I_GPR_WDATA, I_SEL_WE, I_SEL_IDX} = '0;
    {I_SEL_WDATA, I_XFER_CS_LOAD, I_XFER_CS, I_XFER_CS_D32, I_IP_LOAD} = '0;
    {I_IP_DATA, I_ADDR_OVR, I_OP_OVR, I_TASK_SWITCH, I_INT_ENTRY} = '0;
    {I_INT_VIA_TASK, I_NEW_FLAGS, I_PUSH_FLAGS, I_POP_FLAGS, I_POP_DATA} = '0;
    {I_LOAD_FLAGS_TO_ACC, I_STORE_ACC_TO_FLAGS, I_ACC_HIGH_BYTE} = '0;
    repeat (3) @(posedge I_CLK);
    chk(O_FLAGS, 32'h0000_0002);
    chk(O_ADDR_LIMIT, 32'h0000_ffff);
    I_RST_N <= 1'b1;
    for (int i = 0; i < 8; i++)
      wre(12'(4 * i), 32'h0101_0101 * 32'(i + 1), 1'b0);
    for (int i = 0; i < 8; i++)
      rdc(12'(4 * i), 32'h0101_0101 * 32'(i + 1));
    wre(12'h000, 32'h1234_5678, 1'b0);
    wre(12'h020, 32'h0000_abcd, 1'b0);
    rdc(12'h000, 32'h1234_abcd);
    wre(12'h040, 32'h0000_0011, 1'b0);
    wre(12'h050, 32'h0000_0022, 1'b0);
    rdc(12'h000, 32'h1234_2211);
    rdc(12'h050, 32'h0000_0022);
    I_GPR_IDX <= GPR_COUNT;
    I_GPR_VIEW <= VIEW_HIGH;
    I_GPR_WDATA <= 32'h0000_005a;
    pulse(6);
    rdc(12'h004, 32'h0202_5a02);
    // Core word write: the upper half of the data must be ignored.
    I_GPR_IDX <= GPR_DST;
    I_GPR_VIEW <= VIEW_WORD;
    I_GPR_WDATA <= 32'hffff_1234;
    pulse(6);
    rdc(12'h01c, 32'h0808_1234);
    I_GPR_IDX <= GPR_STACK;
    I_GPR_VIEW <= VIEW_LOW;
    pulse(6);
    rdc(12'h010, 32'h0505_0505);
    for (int k = 1; k < 6; k++)
      wre(12'h060 + 12'(4 * k), 32'h0000_1111 * 32'(k), 1'b0);
    for (int k = 1; k < 6; k++)
      rdc(12'h060 + 12'(4 * k), 32'h0000_1111 * 32'(k));
    nclk(3);
    chk(O_STACK_SEL, 32'h0000_2222);
    I_XFER_CS <= 16'h2468;
    I_XFER_CS_D32 <= 1'b1;
    pulse(8);
    I_IP_DATA <= 32'h0000_1000;
    pulse(9);
    wre(12'h060, 32'h0000_ffff, 1'b1);
    I_SEL_IDX <= SEL_CODE;
    I_SEL_WDATA <= 16'habcd;
    pulse(7);
    rdc(12'h060, 32'h0000_2468);
    I_SEL_IDX <= SEL_STACK;
    pulse(7);
    rdc(12'h068, 32'h0000_abcd);
    wre(12'h080, 32'h0000_0000, 1'b1);
    wre(12'h084, 32'h0000_0000, 1'b1);
    nclk(3);
    chk(O_FETCH_SEL, 32'h0000_2468);
    chk(O_FETCH_OFS, 32'h0000_1000);
    chk(O_OP32, 32'h0000_0000);
    rdc(12'h07c, 32'h0000_0000);
    I_ADDR_OVR <= 1'b1;
    nclk(3);
    chk(O_ADDR32, 32'h0000_0001);
    chk(O_ADDR_LIMIT, 32'h0000_ffff);
    I_ADDR_OVR <= 1'b0;
    wre(12'h078, 32'h0000_0001, 1'b0);
    nclk(3);
    chk(O_ADDR_LIMIT, 32'hffff_ffff);
    rdc(12'h07c, 32'h0000_0003);
    I_OP_OVR <= 1'b1;
    nclk(3);
    chk(O_OP32, 32'h0000_0000);
    I_OP_OVR <= 1'b0;
    I_POP_DATA <= 32'hffff_ffff;
    pulse(3);
    chk(O_FLAGS, 32'h003f_7fd7);
    I_ACC_HIGH_BYTE <= 8'h00;
    pulse(4);
    chk(O_FLAGS, 32'h003f_7f02);
    wre(12'h000, 32'h0000_0000, 1'b0);
    pulse(5);
    rdc(12'h000, 32'h0000_0200);
    I_NEW_FLAGS <= 32'h0000_08c1;
    pulse(0);
    chk(O_SAVE_TO_TSEG, 32'h0000_0001);
    chk(O_SAVE_FLAGS, 32'h003f_7f02);
    chk(O_FLAGS, 32'h0000_08c3);
    pulse(1);
    chk(O_SAVE_VLD, 32'h0000_0001);
    chk(O_SAVE_TO_TSEG, 32'h0000_0000);
    chk(O_SAVE_FLAGS, 32'h0000_08c3);
    I_INT_VIA_TASK <= 1'b1;
    I_NEW_FLAGS <= 32'h0000_08c3;
    pulse(1);
    chk(O_SAVE_TO_TSEG, 32'h0000_0001);
    I_INT_VIA_TASK <= 1'b0;
    pulse(2);
    chk(O_SAVE_TO_TSEG, 32'h0000_0000);
    @(posedge I_CLK);
    I_INIT <= 1'b1;
    nclk(6);
    I_INIT <= 1'b0;
    nclk(2);
    chk(O_FLAGS, 32'h0000_0002);
    chk(O_ADDR_LIMIT, 32'h0000_ffff);
    tally_and_finish();
  end
endmodule
`default_nettype wire
